// ### dtt_pkg.sv
/*
 * dtt_pkg: shared constants for the data cache tag test access block.
 * assumes a 64-bit classic wishbone slave port and one 125 MHz clock.
 */
`default_nettype none

package dtt_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int DTT_AW = 16;
  localparam int DTT_DW = 64;
  localparam int DTT_SW = 8;

  // ************************************************************
  // register indices and byte addresses (index times eight)
  // ************************************************************
  localparam logic [9:0]  IDX_CTL     = 10'h213;
  localparam logic [9:0]  IDX_PROBE   = 10'h214;
  localparam logic [9:0]  IDX_CAPTURE = 10'h215;
  localparam logic [9:0]  IDX_STATUS  = 10'h218;
  localparam logic [9:0]  IDX_MASK    = 10'h219;
  localparam logic [15:0] ADDR_CTL     = {3'h0, IDX_CTL, 3'h0};
  localparam logic [15:0] ADDR_PROBE   = {3'h0, IDX_PROBE, 3'h0};
  localparam logic [15:0] ADDR_CAPTURE = {3'h0, IDX_CAPTURE, 3'h0};
  localparam logic [15:0] ADDR_STATUS  = {3'h0, IDX_STATUS, 3'h0};
  localparam logic [15:0] ADDR_MASK    = {3'h0, IDX_MASK, 3'h0};

  // ************************************************************
  // field positions and widths
  // ************************************************************
  localparam int CTL_W       = 16;
  localparam int CTL_BANK_ZERO_SELECT   = 0;
  localparam int CTL_BANK_ONE_SELECT   = 1;
  localparam int CTL_RAZ     = 2;
  localparam int CTL_IDX_LSB = 3;
  localparam int CTL_IDX_MSB = 13;
  localparam int CTL_CLR_BIT = 15;
  localparam int INDEX_W     = 11;
  localparam int DEPTH       = 2048;
  localparam int TPAR_BIT    = 2;
  localparam int DPAR_LSB    = 3;
  localparam int DPAR_MSB    = 10;
  localparam int OW0_BIT     = 11;
  localparam int OW1_BIT     = 12;
  localparam int TAG_LSB     = 13;
  localparam int TAG_MSB     = 32;
  localparam int TAG_W       = 20;
  localparam int DPAR_W      = 8;
  localparam int CAP_W       = 33;
  localparam int EVT_W       = 4;

  // ************************************************************
  // event bits and reset values
  // ************************************************************
  localparam int EVT_CAPTURE = 0;
  localparam int EVT_WRITE   = 1;
  localparam int EVT_DPAR    = 2;
  localparam int EVT_TPAR    = 3;
  localparam logic [CTL_W-1:0] CTL_RESET  = 16'h0000;
  localparam logic [CAP_W-1:0] CAP_RESET  = 33'h000000000;
  localparam logic [EVT_W-1:0] EVT_RESET  = 4'h0;

  // ************************************************************
  // bus sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    DTT_IDLE   = 3'b001,
    DTT_RDWAIT = 3'b010,
    DTT_ACK    = 3'b100
  } dtt_state_t;

endpackage : dtt_pkg

`default_nettype wire

// ### dtt_tag_ram.sv
/*
 * dtt_tag_ram: two banks of tag, tag parity and octaword valid bits,
 * plus a separate data check bit array per bank.
 * assumes synchronous use: read data appears one edge after rd_en_i.
 */
`timescale 1ns/100ps
`default_nettype none

module dtt_tag_ram (
  input  wire logic                       clk_i,
  input  wire logic                       rd_en_i,
  input  wire logic                       rd_bank_i,
  input  wire logic [dtt_pkg::INDEX_W-1:0] index_i,
  input  wire logic [1:0]                 wr_en_i,
  input  wire logic [dtt_pkg::TAG_W-1:0]  wr_tag_i,
  input  wire logic                       wr_tpar_i,
  input  wire logic [1:0]                 wr_valid_i,
  input  wire logic                       dp_we_i,
  input  wire logic                       dp_bank_i,
  input  wire logic [dtt_pkg::INDEX_W-1:0] dp_index_i,
  input  wire logic [dtt_pkg::DPAR_W-1:0] dp_i,
  output var  logic [dtt_pkg::TAG_W-1:0]  rd_tag_o,
  output var  logic                       rd_tpar_o,
  output var  logic [1:0]                 rd_valid_o,
  output var  logic [dtt_pkg::DPAR_W-1:0] rd_dpar_o
);
  import dtt_pkg::*;

  // ************************************************************
  // storage: check bits kept apart so tag writes cannot touch them
  // ************************************************************
  logic [TAG_W+2:0]  tag_mem  [0:1][0:DEPTH-1];
  logic [DPAR_W-1:0] dpar_mem [0:1][0:DEPTH-1];

  always_ff @(posedge clk_i) begin
    for (int b = 0; b < 2; b++) begin
      if (wr_en_i[b]) begin
        tag_mem[b][index_i] <= {wr_tag_i, wr_valid_i, wr_tpar_i};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (dp_we_i) begin
      dpar_mem[dp_bank_i][dp_index_i] <= dp_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rd_en_i) begin
      {rd_tag_o, rd_valid_o, rd_tpar_o} <= tag_mem[rd_bank_i][index_i];
      rd_dpar_o                         <= dpar_mem[rd_bank_i][index_i];
    end
  end

endmodule : dtt_tag_ram

`default_nettype wire

// ### dtt_test_access.sv
/*
 * dtt_test_access: diagnostic read/write path into the data cache tag
 * array, with index control, probe, capture, status and mask registers.
 * assumes a classic wishbone master on clk_i and a cache fill path on
 * the same clock that loads the data check bits.
 */
`timescale 1ns/100ps
`default_nettype none

// Contract
// [R1] index field bits 13:3 of control selects the tag entry for probes
// [R2] reset clears control bit 15
// [R3] bank zero select set reads bank 0, clear reads bank 1
// [R4] bank one select set writes bank 1, never steers reads
// [R5] probe read loads tag, parity, valid and data check bits into capture
// [R6] probe read returns zero on the bus
// [R7] probe write updates tag, parity and valid, leaves data check bits alone
// [R8] probe write goes to each selected bank, both when both set
// [R9] bit 2 of probe and capture is tag parity over tag bits 32:13
// [R10] bits 11 and 12 are low and high octaword valid
// [R11] bits 32:13 of probe and capture map to the stored tag
// [R12] software reads probe first, then capture, to get the data
// [R13] capture bits 10:3 hold the eight data check bits of the read bank
// [R14] software writes control bits 15:14 as zero
// [R15] capture holds its value until the next probe read
module dtt_test_access (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic                        we_i,
  input  wire logic [dtt_pkg::DTT_AW-1:0]  adr_i,
  input  wire logic [dtt_pkg::DTT_SW-1:0]  sel_i,
  input  wire logic [dtt_pkg::DTT_DW-1:0]  dat_i,
  output var  logic [dtt_pkg::DTT_DW-1:0]  dat_o,
  output var  logic                        ack_o,
  output var  logic                        err_o,
  output var  logic                        irq_o,
  input  wire logic                        fill_we_i,
  input  wire logic                        fill_bank_i,
  input  wire logic [dtt_pkg::INDEX_W-1:0] fill_index_i,
  input  wire logic [dtt_pkg::DPAR_W-1:0]  fill_dpar_i
);
  import dtt_pkg::*;

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [DTT_DW-1:0] dtt_merge(
    input logic [DTT_DW-1:0] old_v,
    input logic [DTT_DW-1:0] new_v,
    input logic [DTT_SW-1:0] sel
  );
    logic [DTT_DW-1:0] res;
    res = old_v;
    for (int i = 0; i < DTT_SW; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : dtt_merge

  // even parity over the tag only; valid bits stay outside it
  function automatic logic dtt_parity(input logic [TAG_W-1:0] tag);
    return ^tag;
  endfunction : dtt_parity

  // ************************************************************
  // state
  // ************************************************************
  dtt_state_t         state;
  logic [CTL_W-1:0]   ctl;
  logic [CAP_W-1:0]   capture;
  logic [EVT_W-1:0]   status;
  logic [EVT_W-1:0]   mask;
  logic [EVT_W-1:0]   events;
  logic [DTT_DW-1:0]  next_dat;
  logic               accept;
  logic               hit_ctl;
  logic               hit_probe;
  logic               hit_capture;
  logic               hit_status;
  logic               hit_mask;
  logic               mapped;
  logic               probe_rd;
  logic               probe_wr;
  logic               rd_bank;
  logic [1:0]         wr_en;
  logic [INDEX_W-1:0] index;
  logic [TAG_W-1:0]   rd_tag;
  logic               rd_tpar;
  logic [1:0]         rd_valid;
  logic [DPAR_W-1:0]  rd_dpar;

  // ************************************************************
  // address decode
  // ************************************************************
  assign accept      = cyc_i & stb_i & (state == DTT_IDLE);
  assign hit_ctl     = (adr_i == ADDR_CTL);
  assign hit_probe   = (adr_i == ADDR_PROBE);
  assign hit_capture = (adr_i == ADDR_CAPTURE);
  assign hit_status  = (adr_i == ADDR_STATUS);
  assign hit_mask    = (adr_i == ADDR_MASK);
  assign mapped      = hit_ctl | hit_probe | hit_capture | hit_status | hit_mask;
  assign probe_rd    = accept & ~we_i & hit_probe;
  assign probe_wr    = accept & we_i & hit_probe;

  // ************************************************************
  // tag array steering
  // ************************************************************
  assign index   = ctl[CTL_IDX_MSB:CTL_IDX_LSB];            // [R1]
  assign rd_bank = ~ctl[CTL_BANK_ZERO_SELECT];                         // [R3] [R4]
  assign wr_en   = probe_wr ? {ctl[CTL_BANK_ONE_SELECT], ctl[CTL_BANK_ZERO_SELECT]} : 2'h0; // [R8]

  // tag write carries no check bits, so those stay as filled [R7]
  dtt_tag_ram u_ram (
    .clk_i      (clk_i),
    .rd_en_i    (probe_rd),
    .rd_bank_i  (rd_bank),
    .index_i    (index),
    .wr_en_i    (wr_en),
    .wr_tag_i   (dat_i[TAG_MSB:TAG_LSB]),                  // [R11]
    .wr_tpar_i  (dat_i[TPAR_BIT]),                         // [R9]
    .wr_valid_i ({dat_i[OW1_BIT], dat_i[OW0_BIT]}),        // [R10]
    .dp_we_i    (fill_we_i),
    .dp_bank_i  (fill_bank_i),
    .dp_index_i (fill_index_i),
    .dp_i       (fill_dpar_i),
    .rd_tag_o   (rd_tag),
    .rd_tpar_o  (rd_tpar),
    .rd_valid_o (rd_valid),
    .rd_dpar_o  (rd_dpar)
  );

  // ************************************************************
  // control register
  // ************************************************************
  // bit 2 and bits above 15 read as zero and ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= CTL_RESET;                                     // [R2]
    end else if (accept && we_i && hit_ctl) begin
      ctl <= CTL_W'(dtt_merge({48'h0, ctl}, dat_i, sel_i)
             & {48'h0, ~(16'h0001 << CTL_RAZ)});
    end
  end

  // ************************************************************
  // capture register
  // ************************************************************
  // loaded only when probe data returns, held through other accesses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture <= CAP_RESET;
    end else if (state == DTT_RDWAIT) begin
      capture <= {rd_tag, rd_valid[1], rd_valid[0], rd_dpar, rd_tpar, 2'h0}; // [R5] [R13] [R15]
    end
  end

  // ************************************************************
  // status, mask and interrupt
  // ************************************************************
  always_comb begin
    events              = EVT_RESET;
    events[EVT_CAPTURE] = (state == DTT_RDWAIT);
    events[EVT_WRITE]   = probe_wr;
    events[EVT_DPAR]    = (state == DTT_RDWAIT) && (|rd_dpar);
    events[EVT_TPAR]    = (state == DTT_RDWAIT) && (dtt_parity(rd_tag) != rd_tpar);
  end

  // a new event in the clearing cycle survives the read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= EVT_RESET;
    end else if (accept && !we_i && hit_status) begin
      status <= events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= EVT_RESET;
    end else if (accept && we_i && hit_mask) begin
      mask <= EVT_W'(dtt_merge({60'h0, mask}, dat_i, sel_i)
              & {60'h0, {EVT_W{1'b1}}});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // ************************************************************
  // read data mux
  // ************************************************************
  always_comb begin
    next_dat = 64'h0000000000000000;
    if (hit_ctl) begin
      next_dat = {48'h0, ctl};
    end else if (hit_capture) begin
      next_dat = {31'h0, capture};
    end else if (hit_status) begin
      next_dat = {60'h0, status};
    end else if (hit_mask) begin
      next_dat = {60'h0, mask};
    end
  end

  // ************************************************************
  // bus sequencer
  // ************************************************************
  // probe reads wait one cycle for the array; all else answers at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= DTT_IDLE;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 64'h0000000000000000;
    end else begin
      case (state)
        DTT_IDLE: begin
          ack_o <= 1'b0;
          err_o <= 1'b0;
          if (probe_rd) begin
            state <= DTT_RDWAIT;
          end else if (accept) begin
            state <= DTT_ACK;
            ack_o <= mapped;
            err_o <= ~mapped;
            dat_o <= we_i ? 64'h0000000000000000 : next_dat;
          end
        end
        DTT_RDWAIT: begin
          state <= DTT_ACK;
          ack_o <= 1'b1;
          dat_o <= 64'h0000000000000000;                    // [R6]
        end
        DTT_ACK: begin
          state <= DTT_IDLE;
          ack_o <= 1'b0;
          err_o <= 1'b0;
        end
        default: begin
          state <= DTT_IDLE;
          ack_o <= 1'b0;
          err_o <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_clears_bit: assert property ( // [R2]
    @(posedge clk_i) disable iff (1'b0) rst_i |=> !ctl[CTL_CLR_BIT])
    else $error("control bit 15 not cleared by reset");

  a_probe_read_index: assert property ( // [R1]
    probe_rd |-> (u_ram.index_i == ctl[CTL_IDX_MSB:CTL_IDX_LSB]))
    else $error("probe read used wrong index");

  a_read_bank_sel: assert property ( // [R3]
    probe_rd |-> (u_ram.rd_bank_i == !ctl[CTL_BANK_ZERO_SELECT]))
    else $error("probe read used wrong bank");

  a_write_bank_sel: assert property ( // [R8]
    probe_wr |-> (wr_en == {ctl[CTL_BANK_ONE_SELECT], ctl[CTL_BANK_ZERO_SELECT]}))
    else $error("probe write bank enables wrong");

  a_no_idle_write: assert property ( // [R4]
    !probe_wr |-> (wr_en == 2'h0))
    else $error("tag array written outside a probe write");

  a_write_fields: assert property ( // [R11]
    probe_wr |-> (u_ram.wr_tag_i == dat_i[TAG_MSB:TAG_LSB])
                 && (u_ram.wr_tpar_i == dat_i[TPAR_BIT])
                 && (u_ram.wr_valid_i == dat_i[OW1_BIT:OW0_BIT]))
    else $error("probe write fields misplaced");

  a_probe_zero_data: assert property ( // [R6]
    probe_rd |=> (state == DTT_RDWAIT) ##1 (ack_o && dat_o == 64'h0))
    else $error("probe read did not return zero after two cycles");

  a_capture_load: assert property ( // [R5]
    (state == DTT_RDWAIT) |=> (capture[TAG_MSB:TAG_LSB] == $past(rd_tag))
                             && (capture[TPAR_BIT] == $past(rd_tpar))
                             && (capture[OW1_BIT:OW0_BIT] == $past(rd_valid)))
    else $error("capture did not load probe data");

  a_data_check_bits: assert property ( // [R13]
    (state == DTT_RDWAIT) |=> (capture[DPAR_MSB:DPAR_LSB] == $past(rd_dpar)))
    else $error("capture check bits wrong");

  a_capture_hold: assert property ( // [R15]
    (state != DTT_RDWAIT) |=> $stable(capture))
    else $error("capture changed without a probe read");

  a_ack_one_cycle: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_irq_raise: assert property (
    (|(status & mask)) |=> irq_o)
    else $error("interrupt missing for an unmasked status bit");

  a_irq_quiet: assert property (
    !(|(status & mask)) |=> !irq_o)
    else $error("interrupt raised with no unmasked status bit");

  a_status_set_wins: assert property (
    (events != EVT_RESET) |=> ((status & $past(events)) == $past(events)))
    else $error("status event lost");

  a_status_read_clear: assert property (
    (accept && !we_i && hit_status) |=> (status == $past(events)))
    else $error("status read did not clear");

  a_unmapped_err: assert property (
    (accept && !mapped) |=> (err_o && !ack_o))
    else $error("unmapped access not refused");

  a_mapped_ack: assert property (
    (accept && mapped && !probe_rd) |=> (ack_o && !err_o))
    else $error("mapped access not answered in one cycle");

  a_ctl_raz_bit: assert property (
    !ctl[CTL_RAZ])
    else $error("control bit 2 stored a one");

  c_probe_read: cover property (probe_rd ##2 ack_o);
  c_both_banks: cover property (probe_wr && wr_en == 2'h3);
  c_irq_raised: cover property (!irq_o ##1 irq_o);
  c_capture_read: cover property (accept && !we_i && hit_capture && capture != CAP_RESET);

endmodule : dtt_test_access

`default_nettype wire

// ### dcache_tag_test_access_bench.sv
/*
 * dcache_tag_test_access_bench: self-checking bench for dtt_test_access.
 * assumes dtt_pkg is compiled first; drives the wishbone port and the
 * fill port itself, at the rising edge of a 125 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none

module dcache_tag_test_access_bench;
  import dtt_pkg::*;

  // ************************************************************
  // stimulus signals
  // ************************************************************
  logic              clk_i;
  logic              rst_i;
  logic              cyc_i;
  logic              stb_i;
  logic              we_i;
  logic [15:0]       adr_i;
  logic [7:0]        sel_i;
  logic [63:0]       dat_i;
  logic [63:0]       dat_o;
  logic              ack_o;
  logic              err_o;
  logic              irq_o;
  logic              fill_we_i;
  logic              fill_bank_i;
  logic [10:0]       fill_index_i;
  logic [7:0]        fill_dpar_i;
  int                n_mismatch;
  int                n_checks;
  logic [63:0]       q;
  logic              e;
  logic [10:0]       ix [3];
  logic [19:0]       t0x;
  logic [19:0]       t1x;

  dtt_test_access dut_u (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .cyc_i        (cyc_i),
    .stb_i        (stb_i),
    .we_i         (we_i),
    .adr_i        (adr_i),
    .sel_i        (sel_i),
    .dat_i        (dat_i),
    .dat_o        (dat_o),
    .ack_o        (ack_o),
    .err_o        (err_o),
    .irq_o        (irq_o),
    .fill_we_i    (fill_we_i),
    .fill_bank_i  (fill_bank_i),
    .fill_index_i (fill_index_i),
    .fill_dpar_i  (fill_dpar_i)
  );

  // ************************************************************
  // clock, verdict and watchdog
  // ************************************************************
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // generous: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // answer taken at the rising edge that shows ack or err high, then released
  task automatic wb(input logic w, input logic [15:0] a, input logic [63:0] d,
                    output logic [63:0] rq, output logic re);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 8'hFF;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && err_o !== 1'h1 && n < 50);
    if (n >= 50) n_mismatch++;
    rq = dat_o;
    re = err_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i  <= 1'h0;
  endtask : wb

  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    logic [63:0] rq;
    logic        re;
    wb(1'h1, a, d, rq, re);
    chk({63'h0, re}, 64'h0);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [63:0] exp);
    logic [63:0] rq;
    logic        re;
    wb(1'h0, a, 64'h0, rq, re);
    chk(rq, exp);
    chk({63'h0, re}, 64'h0);
  endtask : rdc

  // bits 15:14 always zero
  task automatic setctl(input logic b0, input logic b1, input logic [10:0] x);
    wr(ADDR_CTL, {48'h0, 2'h0, x, 1'h0, b1, b0});
  endtask : setctl

  // data check field and bits 1:0 deliberately nonzero: both must be ignored
  task automatic pwr(input logic [19:0] t, input logic p, input logic v0, input logic v1);
    wr(ADDR_PROBE, {31'h0, t, v1, v0, 8'hFF, p, 2'h3});
  endtask : pwr

  task automatic fill(input logic b, input logic [10:0] x, input logic [7:0] d);
    @(posedge clk_i);
    fill_we_i    <= 1'h1;
    fill_bank_i  <= b;
    fill_index_i <= x;
    fill_dpar_i  <= d;
    @(posedge clk_i);
    fill_we_i    <= 1'h0;
  endtask : fill

  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({63'h0, irq_o}, {63'h0, v});
  endtask : irq_is

  function automatic logic [63:0] cap(input logic [19:0] t, input logic p,
                                      input logic v0, input logic v1, input logic [7:0] d);
    return {31'h0, t, v1, v0, d, p, 2'h0};
  endfunction : cap

  function automatic logic [19:0] tg(input logic [10:0] x);
    return {9'h150, x};
  endfunction : tg

  function automatic logic [7:0] dp0(input logic [10:0] x);
    return {x[3:0], 4'hA};
  endfunction : dp0

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    rst_i = 1'h1;
    {cyc_i, stb_i, we_i, fill_we_i, fill_bank_i} = 5'h00;
    adr_i = 16'h0000;
    sel_i = 8'h00;
    dat_i = 64'h0;
    fill_index_i = 11'h000;
    fill_dpar_i = 8'h00;
    ix = '{11'h000, 11'h7FF, 11'h2A5};
    t0x = 20'hF0F0F;
    t1x = 20'h0F0F0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rdc(ADDR_CTL, 64'h0);
    rdc(ADDR_CAPTURE, 64'h0);
    wr(ADDR_CTL, 64'hFFFF_0000_0000_3FFF);
    rdc(ADDR_CTL, 64'h3FFB);
    wb(1'h0, 16'h1000, 64'h0, q, e);
    chk({63'h0, e}, 64'h1);
    // both banks written, each bank read back with its own check bits
    for (int i = 0; i < 3; i++) begin
      fill(1'h0, ix[i], dp0(ix[i]));
      fill(1'h1, ix[i], 8'h00);
      setctl(1'h1, 1'h1, ix[i]);
      pwr(tg(ix[i]), ^tg(ix[i]), 1'h1, 1'h0);
      setctl(1'h1, 1'h0, ix[i]);
      rdc(ADDR_PROBE, 64'h0);
      rdc(ADDR_CAPTURE, cap(tg(ix[i]), ^tg(ix[i]), 1'h1, 1'h0, dp0(ix[i])));
      setctl(1'h0, 1'h0, ix[i]);
      rdc(ADDR_PROBE, 64'h0);
      rdc(ADDR_CAPTURE, cap(tg(ix[i]), ^tg(ix[i]), 1'h1, 1'h0, 8'h00));
    end
    // later entries must not have overwritten earlier ones
    for (int i = 0; i < 3; i++) begin
      setctl(1'h1, 1'h0, ix[i]);
      rdc(ADDR_PROBE, 64'h0);
      rdc(ADDR_CAPTURE, cap(tg(ix[i]), ^tg(ix[i]), 1'h1, 1'h0, dp0(ix[i])));
    end
    // single-bank writes
    setctl(1'h1, 1'h0, ix[2]);
    pwr(t0x, ^t0x, 1'h0, 1'h1);
    setctl(1'h0, 1'h1, ix[2]);
    pwr(t1x, ^t1x, 1'h1, 1'h1);
    setctl(1'h1, 1'h1, ix[2]);
    rdc(ADDR_PROBE, 64'h0);
    rdc(ADDR_CAPTURE, cap(t0x, ^t0x, 1'h0, 1'h1, dp0(ix[2])));
    setctl(1'h0, 1'h1, ix[2]);
    rdc(ADDR_PROBE, 64'h0);
    rdc(ADDR_CAPTURE, cap(t1x, ^t1x, 1'h1, 1'h1, 8'h00));
    // a probe write after a fill keeps the fill's check bits
    fill(1'h0, ix[2], 8'h3C);
    setctl(1'h1, 1'h0, ix[2]);
    pwr(t1x, ^t1x, 1'h1, 1'h0);
    rdc(ADDR_PROBE, 64'h0);
    rdc(ADDR_CAPTURE, cap(t1x, ^t1x, 1'h1, 1'h0, 8'h3C));
    pwr(t0x, ^t0x, 1'h0, 1'h0);
    setctl(1'h0, 1'h0, ix[0]);
    rdc(ADDR_CAPTURE, cap(t1x, ^t1x, 1'h1, 1'h0, 8'h3C));
    // status, mask and interrupt; events so far: capture, write, check bits
    irq_is(1'h0);
    rdc(ADDR_STATUS, 64'h7);
    rdc(ADDR_STATUS, 64'h0);
    wr(ADDR_STATUS, 64'hF);
    rdc(ADDR_STATUS, 64'h0);
    wr(ADDR_MASK, 64'h2);
    rdc(ADDR_MASK, 64'h2);
    rdc(ADDR_PROBE, 64'h0);
    irq_is(1'h0);
    rdc(ADDR_STATUS, 64'h1);
    setctl(1'h1, 1'h0, ix[0]);
    pwr(t0x, ~^t0x, 1'h0, 1'h0);
    irq_is(1'h1);
    rdc(ADDR_PROBE, 64'h0);
    rdc(ADDR_STATUS, 64'hF);
    irq_is(1'h0);
    rdc(ADDR_CAPTURE, cap(t0x, ~^t0x, 1'h0, 1'h0, dp0(ix[0])));
    conclude();
  end

endmodule : dcache_tag_test_access_bench

`default_nettype wire
